// >>> rtl/ptfc_checker.sv
// pasid-table entry fault checker top with status, mask and interrupt
// Functional notes
// - entry not present gives qualified fault, reason 59h
// - not present: untranslated UR, translation success zero perms, page IR or drop
// - reserved bits set: reason 5Ah; UR, CA, IR or drop
// - invalid programming reports 5Bh as qualified fault; page requests only for address width or type select
// - unsupported address width: UR, CA, IR or drop
// - type select 000b, 101b, 110b, 111b always invalid
// - type select 001b to 100b invalid when its capability is clear
// - bad first-level paging mode: 5Bh, UR or CA, page requests exempt
// - bad extended memory type: 5Bh, UR or CA, page requests exempt
// - execute without enable on pasid request: 5Ch, UR or success zero
// - privileged without supervisor enable: 5Dh, UR or success zero
// - privilege comes from request or from context default privilege
// - entry fetch error: 58h, non-qualified; UR, CA, IR or drop
module ptfc_checker (
  input  wire logic       CLK_SYS,
  input  wire logic       RSTN,
  input  wire logic       REQ_VALID,
  input  wire logic [2:0] REQ_CLASS,
  input  wire logic       REQ_WITH_PASID,
  input  wire logic       EXECUTE_REQUESTED,
  input  wire logic       PRIVILEGED_REQUESTED,
  input  wire logic       USE_DEFAULT_PRIVILEGE,
  input  wire logic       REQUESTER_DEFAULT_PRIVILEGE,
  input  wire logic       ENTRY_FETCH_ERROR,
  input  wire logic       ENTRY_PRESENT,
  input  wire logic       ENTRY_RSVD_NONZERO,
  input  wire logic       ADDRESS_WIDTH_UNSUPPORTED,
  input  wire logic [2:0] TRANSLATION_TYPE_SELECT,
  input  wire logic       FIRST_LEVEL_PAGING_MODE_UNSUPPORTED,
  input  wire logic       EXTENDED_MEMTYPE_UNSUPPORTED,
  input  wire logic       EXECUTE_REQUEST_ENABLE,
  input  wire logic       SUPERVISOR_REQUEST_ENABLE,
  input  wire logic       FIRST_LEVEL_SUPPORT,
  input  wire logic       SECOND_LEVEL_SUPPORT,
  input  wire logic       NESTED_SUPPORT,
  input  wire logic       PASSTHROUGH_SUPPORT,
  input  wire logic [1:0] REG_ADDR,
  input  wire logic [7:0] REG_WDATA,
  input  wire logic       REG_WR,
  input  wire logic       REG_RD,
  output logic [7:0]      REG_RDATA,
  output logic            RSP_VALID,
  output logic            RSP_FAULT,
  output logic            RSP_QUALIFIED,
  output logic [7:0]      RSP_REASON,
  output logic [2:0]      RSP_ACTION,
  output logic            IRQ
);
  logic                     fault;
  logic                     qualified;
  logic [7:0]               reason;
  logic [2:0]               action;
  logic [5:0]               ev;
  logic                     priv_eff;
  logic [ptfc_pkg::ST_W-1:0] status_q;
  logic [ptfc_pkg::ST_W-1:0] status_d;
  logic [ptfc_pkg::ST_W-1:0] mask_q;
  logic [7:0]               last_reason_q;
  logic                     irq_d;

  // privilege may be supplied by context default instead of the request
  assign priv_eff = USE_DEFAULT_PRIVILEGE ? REQUESTER_DEFAULT_PRIVILEGE
                                          : PRIVILEGED_REQUESTED;

  ptfc_decide u_decide (
    .fetch_err (ENTRY_FETCH_ERROR),
    .present   (ENTRY_PRESENT),
    .rsvd_nz   (ENTRY_RSVD_NONZERO),
    .aw_bad    (ADDRESS_WIDTH_UNSUPPORTED),
    .tt_sel    (TRANSLATION_TYPE_SELECT),
    .caps      ({PASSTHROUGH_SUPPORT, NESTED_SUPPORT, SECOND_LEVEL_SUPPORT,
                 FIRST_LEVEL_SUPPORT}),
    .first_level_paging_mode_bad  (FIRST_LEVEL_PAGING_MODE_UNSUPPORTED),
    .emt_bad   (EXTENDED_MEMTYPE_UNSUPPORTED),
    .with_pasid(REQ_WITH_PASID),
    .exec_req  (EXECUTE_REQUESTED),
    .exec_en   (EXECUTE_REQUEST_ENABLE),
    .priv_eff  (priv_eff),
    .sup_en    (SUPERVISOR_REQUEST_ENABLE),
    .rq_class  (REQ_CLASS),
    .fault     (fault),
    .qualified (qualified),
    .reason    (reason),
    .action    (action),
    .ev        (ev)
  );

  // one-cycle registered verdict for each request
  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      RSP_VALID     <= 1'b0;
      RSP_FAULT     <= 1'b0;
      RSP_QUALIFIED <= 1'b0;
      RSP_REASON    <= ptfc_pkg::FR_NONE;
      RSP_ACTION    <= ptfc_pkg::ACT_OK;
    end else begin
      RSP_VALID     <= REQ_VALID;
      RSP_FAULT     <= REQ_VALID & fault;
      RSP_QUALIFIED <= REQ_VALID & qualified;
      RSP_REASON    <= REQ_VALID ? reason : ptfc_pkg::FR_NONE;
      RSP_ACTION    <= REQ_VALID ? action : ptfc_pkg::ACT_OK;
    end
  end

  // a new event in the read cycle survives the clear-on-read
  always_comb begin
    status_d = status_q;
    if (REG_RD && REG_ADDR == ptfc_pkg::ADDR_STATUS) begin
      status_d = '0;
    end
    if (REQ_VALID) begin
      status_d = status_d | ev;
    end
  end

  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      status_q <= '0;
    end else begin
      status_q <= status_d;
    end
  end

  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      mask_q <= ptfc_pkg::MASK_RESET;
    end else if (REG_WR && REG_ADDR == ptfc_pkg::ADDR_MASK) begin
      mask_q <= REG_WDATA[ptfc_pkg::ST_W-1:0];
    end
  end

  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      last_reason_q <= ptfc_pkg::FR_NONE;
    end else if (REQ_VALID && fault) begin
      last_reason_q <= reason;
    end
  end

  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      REG_RDATA <= 8'h00;
    end else if (REG_RD) begin
      case (REG_ADDR)
        ptfc_pkg::ADDR_STATUS: REG_RDATA <= {2'h0, status_q};
        ptfc_pkg::ADDR_MASK:   REG_RDATA <= {2'h0, mask_q};
        ptfc_pkg::ADDR_LAST:   REG_RDATA <= last_reason_q;
        default:               REG_RDATA <= 8'h00;
      endcase
    end else begin
      REG_RDATA <= 8'h00;
    end
  end

  // irq registered from masked next status: changes at the same edge as status
  assign irq_d = |(status_d & mask_q);

  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      IRQ <= 1'b0;
    end else begin
      IRQ <= irq_d;
    end
  end

  property p_fetch_err;
    @(posedge CLK_SYS) disable iff (!RSTN)
      (REQ_VALID && ENTRY_FETCH_ERROR && REQ_CLASS != ptfc_pkg::RQ_TRANSLATED
       && REQ_CLASS <= ptfc_pkg::RQ_PAGE_NORESP)
      |=> (RSP_REASON == 8'h58 && !RSP_QUALIFIED && RSP_FAULT);
  endproperty
  a_fetch_err: assert property (p_fetch_err) else $error("fetch error verdict wrong");

  property p_np;
    @(posedge CLK_SYS) disable iff (!RSTN)
      (REQ_VALID && !ENTRY_FETCH_ERROR && !ENTRY_PRESENT
       && REQ_CLASS == ptfc_pkg::RQ_TRANSREQ)
      |=> (RSP_REASON == 8'h59 && RSP_ACTION == ptfc_pkg::ACT_SUCC0 && RSP_QUALIFIED);
  endproperty
  a_np: assert property (p_np) else $error("not-present verdict wrong");

  property p_rsvd;
    @(posedge CLK_SYS) disable iff (!RSTN)
      (REQ_VALID && !ENTRY_FETCH_ERROR && ENTRY_PRESENT && ENTRY_RSVD_NONZERO
       && REQ_CLASS == ptfc_pkg::RQ_PAGE_NORESP)
      |=> (RSP_REASON == 8'h5A && RSP_ACTION == ptfc_pkg::ACT_DROP);
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved verdict wrong");

  property p_tt;
    @(posedge CLK_SYS) disable iff (!RSTN)
      (REQ_VALID && !ENTRY_FETCH_ERROR && ENTRY_PRESENT && !ENTRY_RSVD_NONZERO
       && TRANSLATION_TYPE_SELECT == 3'h0 && REQ_CLASS == ptfc_pkg::RQ_TRANSREQ)
      |=> (RSP_REASON == 8'h5B && RSP_ACTION == ptfc_pkg::ACT_CA);
  endproperty
  a_tt: assert property (p_tt) else $error("type select verdict wrong");

  // a page request that needs a response must still be answered for a missing entry
  property p_np_page;
    @(posedge CLK_SYS) disable iff (!RSTN)
      (REQ_VALID && !ENTRY_FETCH_ERROR && !ENTRY_PRESENT
       && REQ_CLASS == ptfc_pkg::RQ_PAGE_RESP)
      |=> (RSP_FAULT && RSP_REASON == 8'h59 && RSP_ACTION == ptfc_pkg::ACT_IR);
  endproperty
  a_np_page: assert property (p_np_page) else $error("not-present page verdict wrong");

  property p_translated;
    @(posedge CLK_SYS) disable iff (!RSTN)
      (REQ_VALID && REQ_CLASS == ptfc_pkg::RQ_TRANSLATED) |=> (!RSP_FAULT && RSP_VALID);
  endproperty
  a_translated: assert property (p_translated) else $error("translated was checked");

  property p_exec;
    @(posedge CLK_SYS) disable iff (!RSTN)
      RSP_VALID && RSP_REASON == 8'h5C |-> $past(REQ_WITH_PASID) && $past(EXECUTE_REQUESTED)
                                           && !$past(EXECUTE_REQUEST_ENABLE);
  endproperty
  a_exec: assert property (p_exec) else $error("execute fault without cause");

  property p_priv;
    @(posedge CLK_SYS) disable iff (!RSTN)
      RSP_VALID && RSP_REASON == 8'h5D |-> !$past(SUPERVISOR_REQUEST_ENABLE)
                                           && RSP_ACTION != ptfc_pkg::ACT_CA;
  endproperty
  a_priv: assert property (p_priv) else $error("privilege fault without cause");

  property p_page_exempt;
    @(posedge CLK_SYS) disable iff (!RSTN)
      (REQ_VALID && ENTRY_PRESENT && !ENTRY_FETCH_ERROR && !ENTRY_RSVD_NONZERO
       && !ADDRESS_WIDTH_UNSUPPORTED && TRANSLATION_TYPE_SELECT == ptfc_pkg::TT_PASS
       && PASSTHROUGH_SUPPORT && REQ_CLASS == ptfc_pkg::RQ_PAGE_RESP)
      |=> !RSP_FAULT;
  endproperty
  a_page_exempt: assert property (p_page_exempt) else $error("page request faulted");
endmodule

// >>> rtl/ptfc_pkg.sv
// constants and types for the pasid-table entry fault checker
package ptfc_pkg;
  localparam logic [7:0] FR_FETCH_ERR   = 8'h58;
  localparam logic [7:0] FR_NOT_PRESENT = 8'h59;
  localparam logic [7:0] FR_RSVD        = 8'h5A;
  localparam logic [7:0] FR_BAD_PROG    = 8'h5B;
  localparam logic [7:0] FR_EXEC        = 8'h5C;
  localparam logic [7:0] FR_PRIV        = 8'h5D;
  localparam logic [7:0] FR_NONE        = 8'h00;

  localparam logic [2:0] TT_FIRST  = 3'h1;
  localparam logic [2:0] TT_SECOND = 3'h2;
  localparam logic [2:0] TT_NESTED = 3'h3;
  localparam logic [2:0] TT_PASS   = 3'h4;

  // request classes
  localparam logic [2:0] RQ_UNTRANS   = 3'h0;
  localparam logic [2:0] RQ_TRANSREQ  = 3'h1;
  localparam logic [2:0] RQ_TRANSLATED = 3'h2;
  localparam logic [2:0] RQ_PAGE_RESP = 3'h3;
  localparam logic [2:0] RQ_PAGE_NORESP = 3'h4;

  // completion actions
  localparam logic [2:0] ACT_OK      = 3'h0;
  localparam logic [2:0] ACT_UR      = 3'h1;
  localparam logic [2:0] ACT_CA      = 3'h2;
  localparam logic [2:0] ACT_SUCC0   = 3'h3;
  localparam logic [2:0] ACT_IR      = 3'h4;
  localparam logic [2:0] ACT_DROP    = 3'h5;

  // status / mask bit positions
  localparam int ST_FETCH = 0;
  localparam int ST_NP    = 1;
  localparam int ST_RSVD  = 2;
  localparam int ST_PROG  = 3;
  localparam int ST_EXEC  = 4;
  localparam int ST_PRIV  = 5;
  localparam int ST_W     = 6;

  localparam logic [1:0] ADDR_STATUS = 2'h0;
  localparam logic [1:0] ADDR_MASK   = 2'h1;
  localparam logic [1:0] ADDR_LAST   = 2'h2;
  localparam logic [ST_W-1:0] MASK_RESET = 6'h00;
endpackage

// >>> rtl/ptfc_decide.sv
// combinational fault priority and action decode
module ptfc_decide (
  input  wire logic       fetch_err,
  input  wire logic       present,
  input  wire logic       rsvd_nz,
  input  wire logic       aw_bad,
  input  wire logic [2:0] tt_sel,
  input  wire logic [3:0] caps,
  input  wire logic       first_level_paging_mode_bad,
  input  wire logic       emt_bad,
  input  wire logic       with_pasid,
  input  wire logic       exec_req,
  input  wire logic       exec_en,
  input  wire logic       priv_eff,
  input  wire logic       sup_en,
  input  wire logic [2:0] rq_class,
  output logic            fault,
  output logic            qualified,
  output logic [7:0]      reason,
  output logic [2:0]      action,
  output logic [5:0]      ev
);
  logic tt_bad;
  logic is_page;
  logic is_trq;

  // map a request class to the action for this fault
  function automatic logic [2:0] act_of(input logic [2:0] cls, input logic succ0,
                                        input logic page_ok);
    case (cls)
      ptfc_pkg::RQ_UNTRANS:     act_of = ptfc_pkg::ACT_UR;
      ptfc_pkg::RQ_TRANSREQ:    act_of = succ0 ? ptfc_pkg::ACT_SUCC0 : ptfc_pkg::ACT_CA;
      ptfc_pkg::RQ_PAGE_RESP:   act_of = page_ok ? ptfc_pkg::ACT_IR : ptfc_pkg::ACT_OK;
      ptfc_pkg::RQ_PAGE_NORESP: act_of = page_ok ? ptfc_pkg::ACT_DROP : ptfc_pkg::ACT_OK;
      default:                  act_of = ptfc_pkg::ACT_OK;
    endcase
  endfunction

  always_comb begin
    case (tt_sel)
      ptfc_pkg::TT_FIRST:  tt_bad = ~caps[0];
      ptfc_pkg::TT_SECOND: tt_bad = ~caps[1];
      ptfc_pkg::TT_NESTED: tt_bad = ~caps[2];
      ptfc_pkg::TT_PASS:   tt_bad = ~caps[3];
      default:             tt_bad = 1'b1;
    endcase
  end

  assign is_page = (rq_class == ptfc_pkg::RQ_PAGE_RESP) |
                   (rq_class == ptfc_pkg::RQ_PAGE_NORESP);
  assign is_trq  = (rq_class == ptfc_pkg::RQ_UNTRANS) | (rq_class == ptfc_pkg::RQ_TRANSREQ);

  always_comb begin
    fault     = 1'b0;
    qualified = 1'b0;
    reason    = ptfc_pkg::FR_NONE;
    action    = ptfc_pkg::ACT_OK;
    ev        = 6'h00;
    // translated requests and undefined classes never fault
    if (rq_class == ptfc_pkg::RQ_TRANSLATED || rq_class > ptfc_pkg::RQ_PAGE_NORESP) begin
      fault = 1'b0;
    end else if (fetch_err) begin
      fault = 1'b1;
      reason = ptfc_pkg::FR_FETCH_ERR;
      action = act_of(rq_class, 1'b0, 1'b1);
      ev[ptfc_pkg::ST_FETCH] = 1'b1;
    end else if (!present) begin
      fault = 1'b1;
      qualified = 1'b1;
      reason = ptfc_pkg::FR_NOT_PRESENT;
      action = act_of(rq_class, 1'b1, 1'b1);
      ev[ptfc_pkg::ST_NP] = 1'b1;
    end else if (rsvd_nz) begin
      fault = 1'b1;
      qualified = 1'b1;
      reason = ptfc_pkg::FR_RSVD;
      action = act_of(rq_class, 1'b0, 1'b1);
      ev[ptfc_pkg::ST_RSVD] = 1'b1;
    end else if (aw_bad || tt_bad) begin
      fault = 1'b1;
      qualified = 1'b1;
      reason = ptfc_pkg::FR_BAD_PROG;
      action = act_of(rq_class, 1'b0, 1'b1);
      ev[ptfc_pkg::ST_PROG] = 1'b1;
    end else if ((first_level_paging_mode_bad || emt_bad) && !is_page) begin
      fault = 1'b1;
      qualified = 1'b1;
      reason = ptfc_pkg::FR_BAD_PROG;
      action = act_of(rq_class, 1'b0, 1'b0);
      ev[ptfc_pkg::ST_PROG] = 1'b1;
    end else if (is_trq && with_pasid && exec_req && !exec_en) begin
      fault = 1'b1;
      qualified = 1'b1;
      reason = ptfc_pkg::FR_EXEC;
      action = act_of(rq_class, 1'b1, 1'b0);
      ev[ptfc_pkg::ST_EXEC] = 1'b1;
    end else if (is_trq && priv_eff && !sup_en) begin
      fault = 1'b1;
      qualified = 1'b1;
      reason = ptfc_pkg::FR_PRIV;
      action = act_of(rq_class, 1'b1, 1'b0);
      ev[ptfc_pkg::ST_PRIV] = 1'b1;
    end
  end
endmodule

// >>> testbench/ptfc_endpoint.sv
// endpoint model that issues requests toward the fault checker
module ptfc_endpoint (
  input  wire logic       clk_sys,
  output logic            req_valid,
  output logic [2:0]      req_class,
  output logic [4:0]      req_bits
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    req_valid = 1'b0;
    req_class = 3'h0;
    req_bits  = 5'h00;
  end
  // bits: pasid, execute, privileged, use default, default privilege
  // fields flip once released, so a stale value can never pass for a live one
  task automatic send(input logic [2:0] c, input logic [4:0] f);
    @(posedge clk_sys);
    req_valid <= 1'b1;
    req_class <= c;
    req_bits  <= f;
    @(posedge clk_sys);
    req_valid <= 1'b0;
    req_class <= ~c;
    req_bits  <= ~f;
  endtask
endmodule

// >>> testbench/ptfc_checker_tb_top.sv
// self-checking bench for the pasid-table entry fault checker
module ptfc_checker_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [10:0] GOOD    = 11'h213;
  localparam logic [10:0] GOOD_PT = 11'h243;
  logic       clk_sys, rstn, req_valid, fe, pres, rsvd, aw, first_level_paging_mode, extended_memtype_field, execute_request_enable, supervisor_request_enable;
  logic       wr, rd, rsp_valid, rsp_fault, rsp_qual, irq;
  logic [2:0] req_class, tt, rsp_action;
  logic [4:0] rb;
  logic [3:0] caps;
  logic [1:0] addr;
  logic [7:0] wdata, rdata, rsp_reason;
  int         n_mismatch, n_checks;

  ptfc_endpoint ptfc_endpoint_i (.clk_sys(clk_sys), .req_valid(req_valid),
    .req_class(req_class), .req_bits(rb));

  ptfc_checker ptfc_checker_i (.CLK_SYS(clk_sys), .RSTN(rstn), .REQ_VALID(req_valid),
    .REQ_CLASS(req_class), .REQ_WITH_PASID(rb[4]), .EXECUTE_REQUESTED(rb[3]),
    .PRIVILEGED_REQUESTED(rb[2]), .USE_DEFAULT_PRIVILEGE(rb[1]),
    .REQUESTER_DEFAULT_PRIVILEGE(rb[0]), .ENTRY_FETCH_ERROR(fe), .ENTRY_PRESENT(pres),
    .ENTRY_RSVD_NONZERO(rsvd), .ADDRESS_WIDTH_UNSUPPORTED(aw), .TRANSLATION_TYPE_SELECT(tt),
    .FIRST_LEVEL_PAGING_MODE_UNSUPPORTED(first_level_paging_mode), .EXTENDED_MEMTYPE_UNSUPPORTED(extended_memtype_field),
    .EXECUTE_REQUEST_ENABLE(execute_request_enable), .SUPERVISOR_REQUEST_ENABLE(supervisor_request_enable),
    .FIRST_LEVEL_SUPPORT(caps[0]), .SECOND_LEVEL_SUPPORT(caps[1]),
    .NESTED_SUPPORT(caps[2]), .PASSTHROUGH_SUPPORT(caps[3]), .REG_ADDR(addr),
    .REG_WDATA(wdata), .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata), .RSP_VALID(rsp_valid),
    .RSP_FAULT(rsp_fault), .RSP_QUALIFIED(rsp_qual), .RSP_REASON(rsp_reason),
    .RSP_ACTION(rsp_action), .IRQ(irq));

  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  task automatic fail(input string m);
    n_mismatch++;
    $display("[FAIL] %0t %s", $time, m);
  endtask
  // qualified is expected low whenever no fault is flagged
  task automatic chk_rsp(input logic f, q, input logic [7:0] r, input logic [2:0] a);
    n_checks++;
    if ({rsp_valid, rsp_fault, rsp_qual, rsp_reason, rsp_action} !== {1'b1, f, f & q, r, a})
      fail($sformatf("rsp f%b q%b r%h a%h", rsp_fault, rsp_qual, rsp_reason, rsp_action));
  endtask
  task automatic chk8(input logic [7:0] e);
    n_checks++;
    if (rdata !== e) fail($sformatf("rdata %h want %h", rdata, e));
  endtask
  task automatic wait_irq(input logic e);
    int i;
    i = 0;
    n_checks++;
    while (irq !== e && i < 4) begin
      @(posedge clk_sys);
      #1;
      i++;
    end
    if (irq !== e) begin
      fail("irq level");
      summarize();
    end
  endtask
  task automatic req(input logic [2:0] c, input logic [4:0] b, input logic f,
                     input logic [7:0] r, input logic [2:0] a);
    ptfc_endpoint_i.send(c, b);
    #1;
    chk_rsp(f, 1'b1, f ? r : ptfc_pkg::FR_NONE, a);
  endtask
  // entry and capabilities change together at one edge, ahead of the request
  task automatic ent(input logic [10:0] v, input logic [3:0] cp = 4'hF);
    @(posedge clk_sys);
    {fe, pres, rsvd, aw, tt, first_level_paging_mode, extended_memtype_field, execute_request_enable, supervisor_request_enable} <= v;
    caps <= cp;
  endtask
  task automatic reg_wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk_sys);
    wr <= 1'b0;
  endtask
  task automatic reg_rd(input logic [1:0] a, input logic [7:0] e);
    @(posedge clk_sys);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk_sys);
    rd <= 1'b0;
    #1;
    chk8(e);
  endtask
  // one request of every class against the entry as it stands
  task automatic all_cls(input logic [7:0] r, input logic q, input logic [2:0] ta, input logic pg);
    logic [2:0] act [5];
    act = '{ptfc_pkg::ACT_UR, ta, ptfc_pkg::ACT_OK, pg ? ptfc_pkg::ACT_IR : ptfc_pkg::ACT_OK,
            pg ? ptfc_pkg::ACT_DROP : ptfc_pkg::ACT_OK};
    for (int c = 0; c < 5; c++) begin
      ptfc_endpoint_i.send(3'(c), 5'h10);
      #1;
      chk_rsp(c < 2 || (c > 2 && pg), q, (c < 2 || (c > 2 && pg)) ? r : 8'h00, act[c]);
    end
  endtask

  task automatic sc_entry;
    ent(GOOD ^ 11'h200);
    all_cls(ptfc_pkg::FR_NOT_PRESENT, 1'b1, ptfc_pkg::ACT_SUCC0, 1'b1);
    ent(GOOD | 11'h100);
    all_cls(ptfc_pkg::FR_RSVD, 1'b1, ptfc_pkg::ACT_CA, 1'b1);
    ent(GOOD ^ 11'h600);
    all_cls(ptfc_pkg::FR_FETCH_ERR, 1'b0, ptfc_pkg::ACT_CA, 1'b1);
  endtask
  task automatic sc_prog;
    logic bad;
    ent(GOOD | 11'h080);
    all_cls(ptfc_pkg::FR_BAD_PROG, 1'b1, ptfc_pkg::ACT_CA, 1'b1);
    for (int t = 0; t < 8; t++) begin
      bad = (t == 0 || t > 4);
      ent({GOOD[10:7], 3'(t), GOOD[3:0]});
      req(3'h0, 5'h10, bad, ptfc_pkg::FR_BAD_PROG,
          bad ? ptfc_pkg::ACT_UR : ptfc_pkg::ACT_OK);
      req(3'h1, 5'h10, bad, ptfc_pkg::FR_BAD_PROG,
          bad ? ptfc_pkg::ACT_CA : ptfc_pkg::ACT_OK);
      if (!bad) begin
        ent({GOOD[10:7], 3'(t), GOOD[3:0]}, ~(4'h1 << (t - 1)));
        req(3'h1, 5'h10, 1'b1, ptfc_pkg::FR_BAD_PROG, ptfc_pkg::ACT_CA);
      end
    end
    // pass-through entry so that the page exemption is seen on a clean entry
    for (int i = 0; i < 2; i++) begin
      ent(GOOD_PT | ((i == 0) ? 11'h008 : 11'h004));
      all_cls(ptfc_pkg::FR_BAD_PROG, 1'b1, ptfc_pkg::ACT_CA, 1'b0);
    end
  endtask
  task automatic sc_perm;
    ent(GOOD ^ 11'h003);
    req(3'h0, 5'h18, 1'b1, ptfc_pkg::FR_EXEC, ptfc_pkg::ACT_UR);
    req(3'h1, 5'h18, 1'b1, ptfc_pkg::FR_EXEC, ptfc_pkg::ACT_SUCC0);
    req(3'h0, 5'h08, 1'b0, 8'h00, ptfc_pkg::ACT_OK);
    req(3'h3, 5'h1C, 1'b0, 8'h00, ptfc_pkg::ACT_OK);
    req(3'h1, 5'h04, 1'b1, ptfc_pkg::FR_PRIV, ptfc_pkg::ACT_SUCC0);
    req(3'h0, 5'h03, 1'b1, ptfc_pkg::FR_PRIV, ptfc_pkg::ACT_UR);
    req(3'h0, 5'h06, 1'b0, 8'h00, ptfc_pkg::ACT_OK);
    ent(GOOD);
    req(3'h0, 5'h1C, 1'b0, 8'h00, ptfc_pkg::ACT_OK);
  endtask
  // every status bit has been set by the earlier scenarios
  task automatic sc_regs;
    reg_rd(ptfc_pkg::ADDR_MASK, 8'h00);
    wait_irq(1'b0);
    reg_wr(ptfc_pkg::ADDR_MASK, 8'h3F);
    reg_rd(ptfc_pkg::ADDR_MASK, 8'h3F);
    wait_irq(1'b1);
    reg_rd(ptfc_pkg::ADDR_LAST, ptfc_pkg::FR_PRIV);
    reg_rd(ptfc_pkg::ADDR_STATUS, 8'h3F);
    wait_irq(1'b0);
    reg_rd(ptfc_pkg::ADDR_STATUS, 8'h00);
    reg_wr(ptfc_pkg::ADDR_MASK, 8'h10);
    ent(GOOD ^ 11'h001);
    req(3'h0, 5'h04, 1'b1, ptfc_pkg::FR_PRIV, ptfc_pkg::ACT_UR);
    wait_irq(1'b0);
    ent(GOOD ^ 11'h003);
    req(3'h0, 5'h1C, 1'b1, ptfc_pkg::FR_EXEC, ptfc_pkg::ACT_UR);
    wait_irq(1'b1);
    reg_wr(2'h3, 8'h55);
    reg_rd(2'h3, 8'h00);
    reg_rd(ptfc_pkg::ADDR_STATUS, 8'h30);
    wait_irq(1'b0);
  endtask

  task automatic summarize;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  initial begin
    n_mismatch = 0;
    n_checks   = 0;
    rstn  = 1'b0;
    wr    = 1'b0;
    rd    = 1'b0;
    addr  = 2'h0;
    wdata = 8'h00;
    {fe, pres, rsvd, aw, tt, first_level_paging_mode, extended_memtype_field, execute_request_enable, supervisor_request_enable} = GOOD;
    caps  = 4'hF;
    repeat (4) @(posedge clk_sys);
    rstn <= 1'b1;
    sc_entry();
    sc_prog();
    sc_perm();
    sc_regs();
    summarize();
  end
endmodule
